// ### gp1_pkg.sv
// constants shared by the eight-pin general-purpose port
package gp1_pkg;
    localparam int GP1_PINS = 8;
    localparam int GP1_ADDR_W = 2;
    localparam int GP1_MODE_W = 3;
    localparam int GP1_AE_W = 4;
    localparam int GP1_UA_W = 4;
    localparam int GP1_SYNC_STAGES = 2;

    // register offsets on the plain register port
    localparam logic [GP1_ADDR_W-1:0] GP1_OFF_PIN_DIRECTION = 2'h0;
    localparam logic [GP1_ADDR_W-1:0] GP1_OFF_OUTPUT_DATA = 2'h1;
    localparam logic [GP1_ADDR_W-1:0] GP1_OFF_PIN_STATE = 2'h2;
    localparam logic [GP1_ADDR_W-1:0] GP1_OFF_PIN_FUNCTION_CONTROL = 2'h3;

    // field layout of pin_function_control
    localparam int GP1_AE_LSB = 0;

    // reset values
    localparam logic [GP1_PINS-1:0] GP1_RST_PIN_DIRECTION = 8'h00;
    localparam logic [GP1_PINS-1:0] GP1_RST_OUTPUT_DATA = 8'h00;
    localparam logic [GP1_AE_W-1:0] GP1_RST_AE = 4'h0;
    localparam logic [GP1_MODE_W-1:0] GP1_RST_MODE = 3'h7;
    localparam logic [GP1_PINS-1:0] GP1_RD_ZERO = 8'h00;

    // operating modes with address output capability
    localparam logic [GP1_MODE_W-1:0] GP1_MODE_ADDR_LO = 3'h4;
    localparam logic [GP1_MODE_W-1:0] GP1_MODE_ADDR_HI = 3'h6;

    // upper_address_enable thresholds per low pin (pin 0 .. pin 3)
    localparam logic [GP1_AE_W-1:0] GP1_AE_MIN_PIN0 = 4'hd;
    localparam logic [GP1_AE_W-1:0] GP1_AE_MIN_PIN1 = 4'he;
    localparam logic [GP1_AE_W-1:0] GP1_AE_MIN_PIN2 = 4'hf;
    localparam logic [GP1_AE_W-1:0] GP1_AE_MIN_PIN3 = 4'hf;

    // cycles after reset release before the mode strap is taken
    localparam logic [1:0] GP1_STRAP_WAIT = 2'h2;
endpackage

// ### gp1_sync.sv
// two-flop synchroniser for levels arriving from outside the clock domain
`timescale 1ns/1ps
module gp1_sync #(
    parameter int WIDTH = 8
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // levels
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_reg;

    // meta_reg is read only by the second stage
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_reg <= '0;
            sync_out <= '0;
        end else begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end
endmodule

// ### gp1_port.sv
// eight-pin general-purpose port: direction, output data, pin readback
// How it works
// - eight pins, each separately an input or an output
// - pin_direction is eight write-only bits, all zero after reset
// - modes 4-6, address enabled: pin 0 from field value d, pins 1..0 from e, pins 3..0 at f drive address, not direction
// - modes 4-6 otherwise: direction bit 1 means output, 0 means input
// - mode 7: direction bit alone picks output (1) or input (0)
// - output_data is 8-bit read/write, resets to zero, drives output pins
// - pin_state read returns output_data bit where direction bit is 1
// - pin_state read returns sampled pin level where direction bit is 0
// - pin_state is read-only and follows the pins after reset
//
// Chosen here: the address-and-strobe port and the address map.
`timescale 1ns/1ps
module gp1_port
    import gp1_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // register port
    input wire logic [gp1_pkg::GP1_ADDR_W-1:0] reg_addr,
    input wire logic [gp1_pkg::GP1_PINS-1:0] reg_wr_data,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [gp1_pkg::GP1_PINS-1:0] reg_rd_data,
    // operating mode strap and address source
    input wire logic [gp1_pkg::GP1_MODE_W-1:0] mode_strap,
    input wire logic [gp1_pkg::GP1_UA_W-1:0] upper_addr,
    // pins
    input wire logic [gp1_pkg::GP1_PINS-1:0] pin_in,
    output logic [gp1_pkg::GP1_PINS-1:0] pin_out,
    output logic [gp1_pkg::GP1_PINS-1:0] pin_oe_n
);
    import gp1_pkg::*;

    logic [GP1_PINS-1:0] dir_reg;
    logic [GP1_PINS-1:0] out_reg;
    logic [GP1_AE_W-1:0] ae_reg;
    logic [GP1_MODE_W-1:0] mode_reg;
    logic mode_seen_reg;
    logic [1:0] strap_cnt_reg;
    logic [GP1_PINS-1:0] pin_sync;
    logic [GP1_MODE_W-1:0] strap_sync;
    logic addr_mode;
    logic [GP1_UA_W-1:0] addr_en;
    logic [GP1_PINS-1:0] pin_out_next;
    logic [GP1_PINS-1:0] pin_oe_n_next;
    logic [GP1_PINS-1:0] state_view;
    logic [GP1_PINS-1:0] rd_data_next;

    // true when the low pin k may carry an upper address line
    function automatic logic ae_covers(input logic [GP1_AE_W-1:0] ae,
                                       input int k);
        logic [GP1_AE_W-1:0] lim;
        case (k)
            0: lim = GP1_AE_MIN_PIN0;
            1: lim = GP1_AE_MIN_PIN1;
            2: lim = GP1_AE_MIN_PIN2;
            default: lim = GP1_AE_MIN_PIN3;
        endcase
        return ae >= lim;
    endfunction

    function automatic logic is_wr(input logic wr,
                                   input logic [GP1_ADDR_W-1:0] a,
                                   input logic [GP1_ADDR_W-1:0] off);
        return wr && (a == off);
    endfunction

    // pins and the strap both come from outside the clock domain
    gp1_sync #(
        .WIDTH(GP1_PINS + GP1_MODE_W)
    ) u_sync (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .async_in({mode_strap, pin_in}),
        .sync_out({strap_sync, pin_sync})
    );

    // strap is taken once, after the synchroniser has filled
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            strap_cnt_reg <= 2'h0;
            mode_seen_reg <= 1'b0;
            mode_reg <= GP1_RST_MODE;
        end else if (!mode_seen_reg) begin
            if (strap_cnt_reg == GP1_STRAP_WAIT) begin
                mode_reg <= strap_sync;
                mode_seen_reg <= 1'b1;
            end else begin
                strap_cnt_reg <= strap_cnt_reg + 2'h1;
            end
        end
    end

    // address output is only possible in modes 4 to 6
    assign addr_mode = mode_seen_reg && (mode_reg >= GP1_MODE_ADDR_LO)
        && (mode_reg <= GP1_MODE_ADDR_HI);

    // write-only direction bits
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            dir_reg <= GP1_RST_PIN_DIRECTION;
        end else if (is_wr(reg_wr, reg_addr, GP1_OFF_PIN_DIRECTION)) begin
            dir_reg <= reg_wr_data;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            out_reg <= GP1_RST_OUTPUT_DATA;
        end else if (is_wr(reg_wr, reg_addr, GP1_OFF_OUTPUT_DATA)) begin
            out_reg <= reg_wr_data;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ae_reg <= GP1_RST_AE;
        end else if (is_wr(reg_wr, reg_addr,
                           GP1_OFF_PIN_FUNCTION_CONTROL)) begin
            ae_reg <= reg_wr_data[GP1_AE_LSB +: GP1_AE_W];
        end
    end

    // pin drive: address lines override direction on the low pins
    always_comb begin
        for (int k = 0; k < GP1_UA_W; k++) begin
            addr_en[k] = addr_mode && ae_covers(ae_reg, k);
        end
        pin_out_next = out_reg;
        pin_oe_n_next = ~dir_reg;
        for (int k = 0; k < GP1_UA_W; k++) begin
            if (addr_en[k]) begin
                pin_out_next[k] = upper_addr[k];
                pin_oe_n_next[k] = 1'b0;
            end
        end
    end

    // registered so the pads see no decode glitches
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_out <= GP1_RST_OUTPUT_DATA;
            pin_oe_n <= ~GP1_RST_PIN_DIRECTION;
        end else begin
            pin_out <= pin_out_next;
            pin_oe_n <= pin_oe_n_next;
        end
    end

    // readback follows direction bits only, even on address-driven pins
    assign state_view = (dir_reg & out_reg)
        | (~dir_reg & pin_sync);

    // write-only and unmapped reads answer zero; there is no readback of
    // direction, so software keeps its own copy
    always_comb begin
        case (reg_addr)
            GP1_OFF_OUTPUT_DATA: rd_data_next = out_reg;
            GP1_OFF_PIN_STATE: rd_data_next = state_view;
            GP1_OFF_PIN_FUNCTION_CONTROL:
                rd_data_next = {{(GP1_PINS-GP1_AE_W){1'b0}}, ae_reg};
            default: rd_data_next = GP1_RD_ZERO;
        endcase
    end

    // a write to pin_state decodes to no register and is dropped
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rd_data <= GP1_RD_ZERO;
        end else if (reg_rd) begin
            reg_rd_data <= rd_data_next;
        end else begin
            reg_rd_data <= GP1_RD_ZERO;
        end
    end

    // checks
    sequence s_state_write;
        reg_wr && reg_addr == GP1_OFF_PIN_STATE;
    endsequence

    sequence s_state_read;
        reg_rd && reg_addr == GP1_OFF_PIN_STATE;
    endsequence

    property p_all_out_gp;
        @(posedge core_clk) disable iff (!rst_n)
        (!addr_mode && dir_reg == 8'hff) |=> pin_oe_n == 8'h00;
    endproperty
    a_all_out_gp: assert property (p_all_out_gp)
        else $error("all-output direction did not enable every pin");

    property p_reset_clear;
        @(posedge core_clk) disable iff (!rst_n)
        (!mode_seen_reg && strap_cnt_reg == 2'h0)
            |-> dir_reg == 8'h00 && out_reg == 8'h00 && pin_oe_n == 8'hff;
    endproperty
    a_reset_clear: assert property (p_reset_clear)
        else $error("direction or output data not zero after reset");

    property p_dir_wo;
        @(posedge core_clk) disable iff (!rst_n)
        (reg_rd && reg_addr == GP1_OFF_PIN_DIRECTION) |=> reg_rd_data == 8'h00;
    endproperty
    a_dir_wo: assert property (p_dir_wo)
        else $error("direction register read back nonzero");

    property p_addr_override;
        @(posedge core_clk) disable iff (!rst_n)
        (addr_mode && ae_reg == 4'hf)
            |=> pin_oe_n[3:0] == 4'h0 && pin_out[3:0] == $past(upper_addr);
    endproperty
    a_addr_override: assert property (p_addr_override)
        else $error("low pins not driving address while enabled");

    property p_addr_pin0_only;
        @(posedge core_clk) disable iff (!rst_n)
        (addr_mode && ae_reg == 4'hd)
            |=> pin_oe_n[0] == 1'b0 && pin_oe_n[3:1] == ~$past(dir_reg[3:1]);
    endproperty
    a_addr_pin0_only: assert property (p_addr_pin0_only)
        else $error("partial address enable set wrong pins");

    property p_addr_pin1;
        @(posedge core_clk) disable iff (!rst_n)
        (addr_mode && ae_reg == 4'he)
            |=> pin_oe_n[1:0] == 2'h0 && pin_oe_n[3:2] == ~$past(dir_reg[3:2]);
    endproperty
    a_addr_pin1: assert property (p_addr_pin1)
        else $error("two-pin address enable set wrong pins");

    property p_low_pins_gp;
        @(posedge core_clk) disable iff (!rst_n)
        (addr_mode && ae_reg < GP1_AE_MIN_PIN0)
            |=> pin_oe_n[3:0] == ~$past(dir_reg[3:0])
            && pin_out[3:0] == $past(out_reg[3:0]);
    endproperty
    a_low_pins_gp: assert property (p_low_pins_gp)
        else $error("low pins with address disabled ignore direction");

    property p_hi_pins_dir;
        @(posedge core_clk) disable iff (!rst_n)
        addr_mode |=> pin_oe_n[7:4] == ~$past(dir_reg[7:4]);
    endproperty
    a_hi_pins_dir: assert property (p_hi_pins_dir)
        else $error("upper pins in address modes ignore direction");

    property p_mode7_dir;
        @(posedge core_clk) disable iff (!rst_n)
        !addr_mode |=> pin_oe_n == ~$past(dir_reg)
            && pin_out == $past(out_reg);
    endproperty
    a_mode7_dir: assert property (p_mode7_dir)
        else $error("general mode pin drive does not follow registers");

    property p_dir_write;
        @(posedge core_clk) disable iff (!rst_n)
        (reg_wr && reg_addr == GP1_OFF_PIN_DIRECTION && !addr_mode)
            |=> ##1 pin_oe_n == ~$past(reg_wr_data, 2);
    endproperty
    a_dir_write: assert property (p_dir_write)
        else $error("direction write did not reach the pin enables");

    property p_out_write;
        @(posedge core_clk) disable iff (!rst_n)
        (reg_wr && reg_addr == GP1_OFF_OUTPUT_DATA && !addr_mode)
            |=> ##1 pin_out == $past(reg_wr_data, 2);
    endproperty
    a_out_write: assert property (p_out_write)
        else $error("output data write did not reach the pins");

    property p_read_driven;
        @(posedge core_clk) disable iff (!rst_n)
        s_state_read |=> (reg_rd_data & $past(dir_reg))
            == ($past(out_reg) & $past(dir_reg));
    endproperty
    a_read_driven: assert property (p_read_driven)
        else $error("output pin readback not from output data");

    property p_read_input;
        @(posedge core_clk) disable iff (!rst_n)
        s_state_read |=> (reg_rd_data & ~$past(dir_reg))
            == ($past(pin_sync) & ~$past(dir_reg));
    endproperty
    a_read_input: assert property (p_read_input)
        else $error("input pin readback not the sampled level");

    property p_state_ro;
        @(posedge core_clk) disable iff (!rst_n)
        s_state_write ##1 s_state_read |=> reg_rd_data
            == (($past(dir_reg) & $past(out_reg))
               | (~$past(dir_reg) & $past(pin_sync)));
    endproperty
    a_state_ro: assert property (p_state_ro)
        else $error("pin_state read affected by a write");

    property p_state_wr_ignored;
        @(posedge core_clk) disable iff (!rst_n)
        s_state_write |=> $stable(out_reg) && $stable(dir_reg);
    endproperty
    a_state_wr_ignored: assert property (p_state_wr_ignored)
        else $error("write to pin_state changed port registers");
endmodule

// ### gp1_pins_model.sv
// board circuitry on the eight port pins: drives inputs, sees driven pins
`timescale 1ns/1ps
module gp1_pins_model
    import gp1_pkg::*;
(
    // port side
    input wire logic [gp1_pkg::GP1_PINS-1:0] pin_out,
    input wire logic [gp1_pkg::GP1_PINS-1:0] pin_oe_n,
    output logic [gp1_pkg::GP1_PINS-1:0] pin_in,
    // level the board puts on pins the port leaves alone
    input wire logic [gp1_pkg::GP1_PINS-1:0] ext_lvl
);
    // a driven pin reads back its own drive, so address pins loop back too
    always_comb begin
        for (int i = 0; i < GP1_PINS; i++) begin
            pin_in[i] = pin_oe_n[i] ? ext_lvl[i] : pin_out[i];
        end
    end
endmodule

// ### gp1_port_test.sv
// self-checking testbench for the eight-pin general-purpose port
`timescale 1ns/1ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin \
    fail_count++; $display("FAIL %0t got %h want %h", $time, a, b); end end
module gp1_port_test;
    import gp1_pkg::*;
    logic core_clk, rst_n, reg_wr, reg_rd;
    logic [GP1_ADDR_W-1:0] reg_addr;
    logic [GP1_PINS-1:0] reg_wr_data, reg_rd_data, pin_in, pin_out, pin_oe_n;
    logic [GP1_PINS-1:0] ext_lvl, rd_d, m;
    logic [GP1_MODE_W-1:0] mode_strap;
    logic [GP1_UA_W-1:0] upper_addr;
    int fail_count, n_compared;

    gp1_port i_dut (.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wr_data(reg_wr_data), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rd_data(reg_rd_data), .mode_strap(mode_strap),
        .upper_addr(upper_addr), .pin_in(pin_in), .pin_out(pin_out),
        .pin_oe_n(pin_oe_n));
    gp1_pins_model i_pins (.pin_out(pin_out), .pin_oe_n(pin_oe_n),
        .pin_in(pin_in), .ext_lvl(ext_lvl));

    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    task automatic wr(input logic [GP1_ADDR_W-1:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wr_data <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [GP1_ADDR_W-1:0] a);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 rd_d = reg_rd_data;
    endtask

    // pin_state write, then a read of it with no idle cycle between strobes
    task automatic wr_rd(input logic [7:0] d);
        @(posedge core_clk);
        reg_addr <= GP1_OFF_PIN_STATE;
        reg_wr_data <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 rd_d = reg_rd_data;
    endtask

    // pins are registered behind the register, so allow two edges and margin
    task automatic settle();
        repeat (3) @(posedge core_clk);
        #1;
    endtask

    // strap is taken on the third edge after release, so wait past it
    task automatic do_reset(input logic [GP1_MODE_W-1:0] md);
        @(posedge core_clk);
        mode_strap <= md;
        rst_n <= 1'b0;
        repeat (3) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge core_clk);
    endtask

    task automatic t_reset_values();
        #1;
        `CHK(pin_oe_n, 8'hff)
        `CHK(pin_out, 8'h00)
        rd(GP1_OFF_OUTPUT_DATA);
        `CHK(rd_d, 8'h00)
        rd(GP1_OFF_PIN_DIRECTION);
        `CHK(rd_d, 8'h00)
        rd(GP1_OFF_PIN_STATE);
        `CHK(rd_d, ext_lvl)
    endtask

    task automatic t_mode7_rw();
        wr(GP1_OFF_PIN_DIRECTION, 8'ha5);
        wr(GP1_OFF_OUTPUT_DATA, 8'h3c);
        settle();
        `CHK(pin_oe_n, 8'h5a)
        `CHK(pin_out & 8'ha5, 8'h24)
        rd(GP1_OFF_PIN_STATE);
        `CHK(rd_d, 8'h3e)
        wr_rd(8'hff);
        `CHK(rd_d, 8'h3e)
        settle();
        rd(GP1_OFF_OUTPUT_DATA);
        `CHK(rd_d, 8'h3c)
        `CHK(pin_oe_n, 8'h5a)
        rd(GP1_OFF_PIN_DIRECTION);
        `CHK(rd_d, 8'h00)
        wr(GP1_OFF_PIN_DIRECTION, 8'hff);
        settle();
        `CHK(pin_oe_n, 8'h00)
        rd(GP1_OFF_PIN_STATE);
        `CHK(rd_d, 8'h3c)
    endtask

    // mode 7 closes the loop: the enable field must then have no effect
    task automatic t_addr_modes();
        logic [3:0] ae_l [5];
        logic [3:0] ae;
        logic [7:0] want;
        ae_l = '{4'h0, 4'hc, 4'hd, 4'he, 4'hf};
        for (int md = 4; md <= 7; md++) begin
            do_reset(md[2:0]);
            wr(GP1_OFF_PIN_DIRECTION, 8'hf0);
            wr(GP1_OFF_OUTPUT_DATA, 8'ha0);
            for (int i = 0; i < 5; i++) begin
                ae = ae_l[i];
                wr(GP1_OFF_PIN_FUNCTION_CONTROL, {4'h0, ae});
                settle();
                m = 8'h00;
                if (md != 7) begin
                    m = {4'h0, ae == 4'hf, ae == 4'hf, ae >= 4'he, ae >= 4'hd};
                end
                `CHK(pin_oe_n, ~(8'hf0 | m))
                want = {4'ha, upper_addr & m[3:0]};
                `CHK(pin_out & (8'hf0 | m), want)
                rd(GP1_OFF_PIN_STATE);
                want[3:0] = want[3:0] | (ext_lvl[3:0] & ~m[3:0]);
                `CHK(rd_d, want)
            end
        end
    endtask

    task automatic stop_test();
        $display("compared %0d, mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    initial begin
        #2000000;
        fail_count++;
        stop_test();
    end

    initial begin
        rst_n = 1'b0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = '0;
        reg_wr_data = '0;
        mode_strap = 3'h7;
        upper_addr = 4'h5;
        ext_lvl = 8'h9a;
        fail_count = 0;
        n_compared = 0;
        do_reset(3'h7);
        t_reset_values();
        t_mode7_rw();
        t_addr_modes();
        stop_test();
    end
endmodule
